// file: rtl/bcr_pkg.sv
// bcr_pkg: constants, register map and carrier types of the buck regulator control register bank.
// assumes one 40 MHz clock, AXI4-Lite register access and an otp image that is stable around reset release.
//
// Function
// [RQ1] registers are readable and writable at any time, whatever the operating state
// [RQ2] reset values come from the otp image, captured just after reset release
// [RQ3] config bit 6 picks ramp rate: 0 one step per 2.0 us, 1 per 4.0 us
// [RQ4] config bits 5:4 hold the switching clock phase code
// [RQ5] config bits 3:2 hold the switching frequency code
// [RQ6] config bit 0 picks current limit: 0 for 2.75 A, 1 for 2.0 A
// [RQ7] channel two config uses the same layout as channel three config
// [RQ8] channel three normal register bits 4:0 give the code used in normal mode
// [RQ9] channel three normal, standby and sleep registers carry a range bit at 5
// [RQ10] channel three standby register bits 4:0 give the code used in standby
// [RQ11] channel three sleep register bits 4:0 give the code used in sleep
// [RQ12] channel three mode bit 5 picks off or sleep after a turn-off event
// [RQ13] mode bit 5 clear turns the channel off, set sends it to sleep
// [RQ14] channel three mode bits 3:0 hold the switching mode selector
// [RQ15] channel four normal register bits 4:0 hold its normal target code
// [RQ16] channel four standby register bits 4:0 give the code used in standby
// [RQ17] unimplemented bits read as zero and ignore writes
// [RQ18] each converter gets the code of the register matching its operating state; in device sleep channel four takes its standby code

`default_nettype none

package bcr_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register map, byte addresses
  localparam int NUM_WR_REGS = 8;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CH2_CONF = 8'h00;
  localparam logic [7:0] ADDR_CH3_NORMAL = 8'h04;
  localparam logic [7:0] ADDR_CH3_STANDBY = 8'h08;
  localparam logic [7:0] ADDR_CH3_SLEEP = 8'h0C;
  localparam logic [7:0] ADDR_CH3_MODE = 8'h10;
  localparam logic [7:0] ADDR_CH3_CONF = 8'h14;
  localparam logic [7:0] ADDR_CH4_NORMAL = 8'h18;
  localparam logic [7:0] ADDR_CH4_STANDBY = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;

  // storage indices (address bits 5:2)
  localparam logic [3:0] IDX_CH2_CONF = 4'h0;
  localparam logic [3:0] IDX_CH3_NORMAL = 4'h1;
  localparam logic [3:0] IDX_CH3_STANDBY = 4'h2;
  localparam logic [3:0] IDX_CH3_SLEEP = 4'h3;
  localparam logic [3:0] IDX_CH3_MODE = 4'h4;
  localparam logic [3:0] IDX_CH3_CONF = 4'h5;
  localparam logic [3:0] IDX_CH4_NORMAL = 4'h6;
  localparam logic [3:0] IDX_CH4_STANDBY = 4'h7;
  localparam logic [3:0] IDX_STATUS = 4'h8;

  ////////////////////////////////////////////////////////////////////////////////
  // field positions and implemented-bit masks
  localparam int CONF_RAMP_BIT = 6;
  localparam int CONF_PHASE_LSB = 4;
  localparam int CONF_FREQ_LSB = 2;
  localparam int CONF_ILIM_BIT = 0;
  localparam int VOLT_RANGE_BIT = 5;
  localparam int MODE_OFFSEL_BIT = 5;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_CODE_LSB = 8;
  localparam int STAT_RANGE_BIT = 13;
  localparam logic [7:0] MASK_CONF = 8'h7D;
  localparam logic [7:0] MASK_VOLT_RANGED = 8'h3F;
  localparam logic [7:0] MASK_VOLT_PLAIN = 8'h1F;
  localparam logic [7:0] MASK_MODE = 8'h2F;
  localparam logic [7:0] REG_RESET = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // ramp timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int RAMP_FAST_NS = 2000;
  localparam int RAMP_SLOW_NS = 4000;
  localparam int RAMP_FAST_CYC = (RAMP_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RAMP_SLOW_CYC = (RAMP_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RAMP_FAST_LAST = 8'(RAMP_FAST_CYC - 1);
  localparam logic [7:0] RAMP_SLOW_LAST = 8'(RAMP_SLOW_CYC - 1);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {OP_NORMAL = 2'h0, OP_STANDBY = 2'h1, OP_SLEEP = 2'h3} bcr_op_type;
  typedef enum logic [1:0] {CH_ON = 2'h0, CH_SLEEP = 2'h1, CH_OFF = 2'h2} bcr_ch_state_type;

  typedef struct packed {
    logic ramp_slow;
    logic [1:0] phase_sel;
    logic [1:0] freq_sel;
    logic current_limit;
  } bcr_conf_type;

  typedef struct packed {
    logic enable;
    logic range_high;
    logic [4:0] code;
    logic [3:0] mode_sel;
  } bcr_ch3_out_type;

endpackage

`default_nettype wire

// file: rtl/bcr_regs.sv
// bcr_regs: AXI4-Lite register bank for buck channels two to four, with the channel three
// off/sleep sequencing and voltage ramp, and per-state code selection for channels three and four.
// assumes op_state and the turn events come from the power sequencer on core_clk,
// and otp_image is the otp shadow, valid when rst releases.

`default_nettype none

module bcr_regs
  import bcr_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // otp defaults, one byte per writable register, by storage index
  input wire logic [NUM_WR_REGS-1:0][7:0] otp_image,
  // device operating state and channel three events
  input wire bcr_op_type op_state,
  input wire logic turn_off_evt,
  input wire logic turn_on_evt,
  // axi4-lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // converter controls
  output bcr_conf_type ch2_conf,
  output bcr_conf_type ch3_conf,
  output bcr_ch3_out_type ch3_ctrl,
  output logic [4:0] ch4_code
);

  ////////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr);
    reg_hit = (addr[1:0] == 2'h0) && (addr <= ADDR_STATUS);
  endfunction

  function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = addr[5:2];
  endfunction

  function automatic logic [7:0] reg_mask(input logic [3:0] idx);
    if (idx == IDX_CH2_CONF || idx == IDX_CH3_CONF) begin
      reg_mask = MASK_CONF;
    end else if (idx == IDX_CH3_NORMAL || idx == IDX_CH3_STANDBY || idx == IDX_CH3_SLEEP) begin
      reg_mask = MASK_VOLT_RANGED;
    end else if (idx == IDX_CH3_MODE) begin
      reg_mask = MASK_MODE;
    end else if (idx == IDX_CH4_NORMAL || idx == IDX_CH4_STANDBY) begin
      reg_mask = MASK_VOLT_PLAIN;
    end else begin
      reg_mask = 8'h00;
    end
  endfunction

  function automatic bcr_conf_type to_conf(input logic [7:0] val);
    to_conf.ramp_slow = val[CONF_RAMP_BIT];
    to_conf.phase_sel = val[CONF_PHASE_LSB +: 2];
    to_conf.freq_sel = val[CONF_FREQ_LSB +: 2];
    to_conf.current_limit = val[CONF_ILIM_BIT];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // register bank and bus slave

  logic [NUM_WR_REGS-1:0][7:0] regs, next_regs;
  logic loading, next_loading;
  logic aw_held, next_aw_held;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic w_held, next_w_held;
  logic [7:0] w_data, next_w_data;
  logic w_lane0, next_w_lane0;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic [31:0] status_word;
  bcr_ch_state_type ch3_state, next_ch3_state;
  logic [7:0] ramp_cnt, next_ramp_cnt;
  logic [7:0] step_last;
  logic [7:0] ch3_sel;
  logic [3:0] wr_idx, rd_idx;

  // storage slots of the held write and of the offered read
  assign wr_idx = reg_index(aw_addr);
  assign rd_idx = reg_index(s_axi_araddr);

  // channel three state as software sees it
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STAT_STATE_LSB +: 2] = ch3_state;
    status_word[STAT_BUSY_BIT] = (ch3_ctrl.code != ch3_sel[4:0]);
    status_word[STAT_CODE_LSB +: 5] = ch3_ctrl.code;
    status_word[STAT_RANGE_BIT] = ch3_ctrl.range_high;
  end

  always_comb begin
    next_regs = regs;
    next_loading = 1'b0;
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (loading) begin
      // the bus stays closed for this cycle and the next, as the ready flags are registered, so no write can race the otp copy
      for (int i = 0; i < NUM_WR_REGS; i++) begin
        next_regs[i] = otp_image[i] & reg_mask(4'(i)); // [RQ2] [RQ17]
      end
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        next_aw_held = 1'b1;
        next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        next_w_held = 1'b1;
        next_w_data = s_axi_wdata[7:0];
        next_w_lane0 = s_axi_wstrb[0];
      end
      if (s_axi_bvalid && s_axi_bready) begin
        next_bvalid = 1'b0;
      end
      // address and data may arrive in either order; commit once both are held
      if (aw_held && w_held && !s_axi_bvalid) begin // [RQ1]
        next_aw_held = 1'b0;
        next_w_held = 1'b0;
        next_bvalid = 1'b1;
        if (reg_hit(aw_addr) && reg_index(aw_addr) != IDX_STATUS) begin
          next_bresp = RESP_OKAY;
          if (w_lane0) begin
            next_regs[wr_idx[2:0]] = w_data & reg_mask(wr_idx); // [RQ17]
          end
        end else begin
          next_bresp = RESP_SLVERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin // [RQ1]
        next_rvalid = 1'b1;
        next_rdata = 32'h0000_0000;
        next_rresp = RESP_SLVERR;
        if (reg_hit(s_axi_araddr)) begin
          next_rresp = RESP_OKAY;
          if (reg_index(s_axi_araddr) == IDX_STATUS) begin
            next_rdata = status_word;
          end else begin
            next_rdata = {24'h00_0000, regs[rd_idx[2:0]]}; // [RQ17]
          end
        end
      end
    end
    next_awready = !next_loading && !next_aw_held && !next_bvalid && !loading;
    next_wready = !next_loading && !next_w_held && !next_bvalid && !loading;
    next_arready = !next_rvalid && !loading;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      regs <= {NUM_WR_REGS{REG_RESET}};
      loading <= 1'b1;
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held <= 1'b0;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      regs <= next_regs;
      loading <= next_loading;
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_lane0 <= next_w_lane0;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // channel sequencing, code selection and ramp

  bcr_conf_type next_ch2_conf, next_ch3_conf;
  bcr_ch3_out_type next_ch3_ctrl;
  logic [4:0] next_ch4_code;

  always_comb begin
    next_ch3_state = ch3_state;
    case (ch3_state)
      CH_ON: begin
        if (turn_off_evt) begin
          next_ch3_state = regs[IDX_CH3_MODE][MODE_OFFSEL_BIT] ? CH_SLEEP : CH_OFF; // [RQ12] [RQ13]
        end
      end
      CH_SLEEP, CH_OFF: begin
        if (turn_on_evt) begin
          next_ch3_state = CH_ON;
        end
      end
      default: begin
        next_ch3_state = CH_ON;
      end
    endcase

    // a channel parked in sleep uses its sleep code even while the device runs normally
    if (ch3_state == CH_SLEEP || op_state == OP_SLEEP) begin
      ch3_sel = regs[IDX_CH3_SLEEP]; // [RQ11] [RQ18]
    end else if (op_state == OP_STANDBY) begin
      ch3_sel = regs[IDX_CH3_STANDBY]; // [RQ10] [RQ18]
    end else begin
      ch3_sel = regs[IDX_CH3_NORMAL]; // [RQ8] [RQ18]
    end

    step_last = regs[IDX_CH3_CONF][CONF_RAMP_BIT] ? RAMP_SLOW_LAST : RAMP_FAST_LAST; // [RQ3]
    next_ramp_cnt = 8'h00;
    next_ch3_ctrl.code = ch3_ctrl.code;
    if (ch3_ctrl.code != ch3_sel[4:0]) begin
      if (ramp_cnt >= step_last) begin
        // one code step per interval; a retarget mid-ramp just changes direction
        next_ch3_ctrl.code = (ch3_ctrl.code < ch3_sel[4:0]) ? 5'(ch3_ctrl.code + 5'h01)
                                                            : 5'(ch3_ctrl.code - 5'h01); // [RQ3]
      end else begin
        next_ramp_cnt = 8'(ramp_cnt + 8'h01);
      end
    end
    next_ch3_ctrl.range_high = ch3_sel[VOLT_RANGE_BIT]; // [RQ9]
    next_ch3_ctrl.enable = (next_ch3_state != CH_OFF); // [RQ13]
    next_ch3_ctrl.mode_sel = regs[IDX_CH3_MODE][3:0]; // [RQ14]

    // channel four has no sleep register here, so device sleep keeps its standby code
    next_ch4_code = (op_state == OP_NORMAL) ? regs[IDX_CH4_NORMAL][4:0] : regs[IDX_CH4_STANDBY][4:0]; // [RQ15] [RQ16]

    next_ch2_conf = to_conf(regs[IDX_CH2_CONF]); // [RQ7]
    next_ch3_conf = to_conf(regs[IDX_CH3_CONF]); // [RQ4] [RQ5] [RQ6]
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ch3_state <= CH_ON;
      ramp_cnt <= 8'h00;
      ch3_ctrl <= '0;
      ch4_code <= 5'h00;
      ch2_conf <= '0;
      ch3_conf <= '0;
    end else begin
      ch3_state <= next_ch3_state;
      ramp_cnt <= next_ramp_cnt;
      ch3_ctrl <= next_ch3_ctrl;
      ch4_code <= next_ch4_code;
      ch2_conf <= next_ch2_conf;
      ch3_conf <= next_ch3_conf;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_write_response: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready) // [RQ1]
      |-> ##2 s_axi_bvalid)
    else $error("write response not two cycles after handshake");

  a_read_answer: assert property ((s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid && !s_axi_arready) // [RQ1]
    else $error("read data not one cycle after address");

  a_status_state: assert property ((s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_STATUS) // [RQ13]
      |=> s_axi_rdata[1:0] == $past(ch3_state))
    else $error("status read lost the channel three state");

  // the attempt at the releasing edge already sees rst low, so rst is sampled as well
  a_otp_capture: assert property ((loading && !rst) // [RQ2]
      |=> regs[IDX_CH3_MODE] == ($past(otp_image[IDX_CH3_MODE]) & MASK_MODE)
      && regs[IDX_CH2_CONF] == ($past(otp_image[IDX_CH2_CONF]) & MASK_CONF))
    else $error("otp defaults not captured");

  // a rate change mid-interval can leave the count past the new end; the step then comes at once
  a_ramp_interval: assert property ($changed(ch3_ctrl.code) |-> $past(ramp_cnt) >= $past(step_last)) // [RQ3]
    else $error("voltage code stepped before its interval");

  a_ramp_size: assert property ($changed(ch3_ctrl.code) |-> // [RQ3]
      (ch3_ctrl.code == 5'($past(ch3_ctrl.code) + 5'h01)) || (ch3_ctrl.code == 5'($past(ch3_ctrl.code) - 5'h01)))
    else $error("voltage code moved more than one step");

  a_ramp_restart: assert property ((ch3_ctrl.code == ch3_sel[4:0]) |=> ramp_cnt == 8'h00) // [RQ3]
    else $error("ramp interval not restarted at the target");

  a_conf_fields: assert property (ch3_conf.phase_sel == $past(regs[IDX_CH3_CONF][5:4]) // [RQ4]
      && ch3_conf.freq_sel == $past(regs[IDX_CH3_CONF][3:2])
      && ch3_conf.current_limit == $past(regs[IDX_CH3_CONF][0]))
    else $error("channel three config fields misplaced");

  a_ch2_layout: assert property (ch2_conf.ramp_slow == $past(regs[IDX_CH2_CONF][6]) // [RQ7]
      && ch2_conf.phase_sel == $past(regs[IDX_CH2_CONF][5:4])
      && ch2_conf.freq_sel == $past(regs[IDX_CH2_CONF][3:2])
      && ch2_conf.current_limit == $past(regs[IDX_CH2_CONF][0]))
    else $error("channel two config fields misplaced");

  a_range_follow: assert property (ch3_ctrl.range_high == $past(ch3_sel[VOLT_RANGE_BIT])) // [RQ9]
    else $error("range bit not taken from the selected register");

  a_mode_follow: assert property (ch3_ctrl.mode_sel == $past(regs[IDX_CH3_MODE][3:0])) // [RQ14]
    else $error("switching mode selector not applied");

  a_sleep_entry: assert property ((ch3_state == CH_ON && turn_off_evt && regs[IDX_CH3_MODE][5]) // [RQ12]
      |=> ch3_state == CH_SLEEP && ch3_ctrl.enable)
    else $error("turn-off did not enter sleep");

  a_off_entry: assert property ((ch3_state == CH_ON && turn_off_evt && !regs[IDX_CH3_MODE][5]) // [RQ13]
      |=> ch3_state == CH_OFF && !ch3_ctrl.enable)
    else $error("turn-off did not switch the channel off");

  a_normal_pick: assert property ((ch3_state == CH_ON && op_state == OP_NORMAL) // [RQ8]
      |-> ch3_sel == regs[IDX_CH3_NORMAL])
    else $error("normal code not selected");

  a_standby_pick: assert property ((ch3_state == CH_ON && op_state == OP_STANDBY) // [RQ18]
      |-> ch3_sel == regs[IDX_CH3_STANDBY])
    else $error("standby code not selected");

  a_sleep_pick: assert property ((ch3_state == CH_SLEEP || op_state == OP_SLEEP) // [RQ11]
      |-> ch3_sel == regs[IDX_CH3_SLEEP])
    else $error("sleep code not selected");

  a_ch4_normal: assert property (op_state == OP_NORMAL // [RQ15]
      |=> ch4_code == $past(regs[IDX_CH4_NORMAL][4:0]))
    else $error("channel four normal code not applied");

  a_ch4_select: assert property (op_state == OP_STANDBY // [RQ16]
      |=> ch4_code == $past(regs[IDX_CH4_STANDBY][4:0]))
    else $error("channel four standby code not applied");

  a_reserved_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:14] == 18'h0_0000 // [RQ17]
      && (regs[IDX_CH3_MODE] & ~MASK_MODE) == 8'h00 && (regs[IDX_CH3_CONF] & ~MASK_CONF) == 8'h00)
    else $error("reserved bits not zero");

  c_write_done: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY);
  c_read_done: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == RESP_OKAY);
  c_sleep_entry: cover property (ch3_state == CH_ON ##1 ch3_state == CH_SLEEP);
  c_off_entry: cover property (ch3_state == CH_ON ##1 ch3_state == CH_OFF);
  c_ramp_step: cover property ($changed(ch3_ctrl.code) && step_last == RAMP_SLOW_LAST);

endmodule

`default_nettype wire

// file: verification/tb.sv
// tb: self-checking bench for the buck regulator control register bank.
// assumes bcr_pkg and bcr_regs are compiled first; the bench drives every port itself.
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import bcr_pkg::*;

  localparam logic [7:0] MASKS [8] = '{MASK_CONF, MASK_VOLT_RANGED, MASK_VOLT_RANGED, MASK_VOLT_RANGED,
                                       MASK_MODE, MASK_CONF, MASK_VOLT_PLAIN, MASK_VOLT_PLAIN};
  localparam logic [33:0] ALL = {34{1'b1}};

  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [NUM_WR_REGS-1:0][7:0] otp_image;
  bcr_op_type op_state = OP_NORMAL;
  logic turn_off_evt = 1'b0;
  logic turn_on_evt = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  bcr_conf_type ch2_conf;
  bcr_conf_type ch3_conf;
  bcr_ch3_out_type ch3_ctrl;
  logic [4:0] ch4_code;

  int errors = 0;
  int comparisons = 0;
  int n;
  logic [31:0] v;
  logic [7:0] sh [8];
  logic [33:0] rd_exp [$];
  logic [33:0] rd_mask [$];
  logic [1:0] wr_exp [$];
  bcr_op_type ops [3] = '{OP_NORMAL, OP_STANDBY, OP_SLEEP};
  logic [4:0] ch3_exp [3] = '{5'h05, 5'h07, 5'h02};
  logic [4:0] ch4_exp [3] = '{5'h0A, 5'h15, 5'h15};
  logic rng_exp [3] = '{1'b1, 1'b0, 1'b1};

  bcr_regs i_bcr_regs (.core_clk(core_clk), .rst(rst), .otp_image(otp_image), .op_state(op_state),
    .turn_off_evt(turn_off_evt), .turn_on_evt(turn_on_evt), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .ch2_conf(ch2_conf), .ch3_conf(ch3_conf), .ch3_ctrl(ch3_ctrl),
    .ch4_code(ch4_code));

  always #12.5 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////////
  // reporting
  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_up();
    errors++;
    $display("wait bound used up at %0t", $time);
    close_out();
  endtask

  function automatic logic [5:0] conf_of(input logic [7:0] r);
    return {r[6], r[5:4], r[3:2], r[0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // bus master; responses are judged by the watcher below
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    int k;
    wr_exp.push_back(r);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && k < 50);
    s_axi_bready <= 1'b0;
    if (k >= 50)
      give_up();
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [33:0] exp, input logic [33:0] msk);
    int k;
    rd_exp.push_back(exp & msk);
    rd_mask.push_back(msk);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready) && k < 50);
    s_axi_rready <= 1'b0;
    if (k >= 50)
      give_up();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    axi_read(a, {RESP_OKAY, 24'h0, d}, ALL);
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  // ramp waits are bounded by 31 slow steps plus margin
  task automatic wait_code(input logic [4:0] tgt);
    n = 0;
    while (ch3_ctrl.code !== tgt && n < 6000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 6000)
      give_up();
  endtask

  task automatic pulse(input logic off);
    @(posedge core_clk);
    turn_off_evt <= off;
    turn_on_evt <= !off;
    @(posedge core_clk);
    turn_off_evt <= 1'b0;
    turn_on_evt <= 1'b0;
    idle(2);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // response watcher: oldest note against each completed transfer
  always @(posedge core_clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      if (rd_exp.size() == 0)
        check(64'h1, 64'h0);
      else
        check({s_axi_rresp, s_axi_rdata} & rd_mask.pop_front(), rd_exp.pop_front());
    end
    if (s_axi_bvalid && s_axi_bready) begin
      if (wr_exp.size() == 0)
        check(64'h1, 64'h0);
      else
        check(s_axi_bresp, wr_exp.pop_front());
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h0B35));
    for (int i = 0; i < NUM_WR_REGS; i++)
      otp_image[i] = 8'($urandom);
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    idle(3);
    check(ch2_conf, conf_of(otp_image[IDX_CH2_CONF]));
    check(ch3_conf, conf_of(otp_image[IDX_CH3_CONF]));
    for (int i = 0; i < NUM_WR_REGS; i++)
      rd(8'(i * 4), otp_image[i] & MASKS[i]);
    // random full-word writes, upper lanes and reserved bits must vanish
    for (int i = 0; i < NUM_WR_REGS; i++) begin
      v = $urandom;
      sh[i] = v[7:0] & MASKS[i];
      axi_write(8'(i * 4), v, 4'hF, RESP_OKAY);
      rd(8'(i * 4), sh[i]);
    end
    axi_write(ADDR_CH2_CONF, 32'hFF, 4'hE, RESP_OKAY);
    rd(ADDR_CH2_CONF, sh[0]);
    axi_write(8'h24, v, 4'hF, RESP_SLVERR);
    axi_write(ADDR_STATUS, v, 4'hF, RESP_SLVERR);
    axi_read(8'h24, {RESP_SLVERR, 32'h0}, ALL);
    axi_read(8'h06, {RESP_SLVERR, 32'h0}, ALL);
    for (int k = 0; k < 4; k++) begin
      v = $urandom;
      axi_write(ADDR_CH2_CONF, v, 4'hF, RESP_OKAY);
      axi_write(ADDR_CH3_CONF, ~v, 4'hF, RESP_OKAY);
      idle(3);
      check(ch2_conf, conf_of(v[7:0]));
      check(ch3_conf, conf_of(~v[7:0]));
    end
    // per-state selection, fast ramp so the targets settle quickly
    axi_write(ADDR_CH3_CONF, 32'h00, 4'hF, RESP_OKAY);
    axi_write(ADDR_CH3_NORMAL, 32'h25, 4'hF, RESP_OKAY);
    axi_write(ADDR_CH3_STANDBY, 32'h07, 4'hF, RESP_OKAY);
    axi_write(ADDR_CH3_SLEEP, 32'h22, 4'hF, RESP_OKAY);
    axi_write(ADDR_CH4_NORMAL, 32'h0A, 4'hF, RESP_OKAY);
    axi_write(ADDR_CH4_STANDBY, 32'h15, 4'hF, RESP_OKAY);
    for (int k = 0; k < 3; k++) begin
      op_state <= ops[k];
      idle(3);
      check(ch3_ctrl.range_high, rng_exp[k]);
      check(ch4_code, ch4_exp[k]);
      wait_code(ch3_exp[k]);
      check(ch3_ctrl.code, ch3_exp[k]);
    end
    op_state <= OP_NORMAL;
    wait_code(5'h05);
    // one step away: time to the step shows the ramp rate
    axi_write(ADDR_CH3_NORMAL, 32'h26, 4'hF, RESP_OKAY);
    wait_code(5'h06);
    check(n >= 74 && n <= 84, 1'b1);
    axi_write(ADDR_CH3_CONF, 32'h40, 4'hF, RESP_OKAY);
    axi_write(ADDR_CH3_NORMAL, 32'h25, 4'hF, RESP_OKAY);
    wait_code(5'h05);
    check(n >= 154 && n <= 164, 1'b1);
    axi_read(ADDR_STATUS, {RESP_OKAY, 32'h2500}, {2'h3, 32'h3F07});
    // turn-off behaviour under both settings of the off-mode bit
    axi_write(ADDR_CH3_MODE, 32'h0B, 4'hF, RESP_OKAY);
    idle(3);
    check(ch3_ctrl.mode_sel, 4'hB);
    pulse(1'b1);
    check(ch3_ctrl.enable, 1'b0);
    axi_read(ADDR_STATUS, {RESP_OKAY, 32'h2}, {2'h3, 32'h3});
    pulse(1'b0);
    check(ch3_ctrl.enable, 1'b1);
    axi_write(ADDR_CH3_MODE, 32'h2B, 4'hF, RESP_OKAY);
    pulse(1'b1);
    axi_read(ADDR_STATUS, {RESP_OKAY, 32'h1}, {2'h3, 32'h3});
    pulse(1'b1);
    axi_read(ADDR_STATUS, {RESP_OKAY, 32'h1}, {2'h3, 32'h3});
    pulse(1'b0);
    axi_read(ADDR_STATUS, {RESP_OKAY, 32'h0}, {2'h3, 32'h3});
    idle(4);
    check(rd_exp.size() + wr_exp.size(), 0);
    close_out();
  end
endmodule

`default_nettype wire
